// ==== include/rscl_pkg.sv ====
package rscl_pkg;
  localparam int ADDR_W = 20;
  // pin positions (pin n sits at bit n-1)
  localparam int POS_ENDIAN = 19;
  localparam int POS_BOOT = 17;
  localparam int POS_WCLK = 15;
  localparam int POS_NCLK = 13;
  localparam int POS_EEPROM_AUTO_INIT_STRAP = 12;
  localparam int POS_CELL = 10;
  localparam int POS_ID_LO = 6;
  // reset values (pin pull defaults)
  localparam logic [19:0] STRAP_RESET = 20'h40000;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  typedef enum logic [1:0] {
    RSCL_BOOT_NONE = 2'b00,
    RSCL_BOOT_HOST = 2'b01,
    RSCL_BOOT_ROM8 = 2'b10,
    RSCL_BOOT_RSVD = 2'b11
  } rscl_boot_t;
  typedef enum logic [1:0] {
    RSCL_CLK_EXT = 2'b00,
    RSCL_CLK_DIV4 = 2'b01,
    RSCL_CLK_DIV6 = 2'b10,
    RSCL_CLK_RSVD = 2'b11
  } rscl_clk_t;
endpackage

// ==== rtl/rscl_strap_latch.sv ====
`timescale 1ns/1ns
`default_nettype none
module rscl_strap_latch
  import rscl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // address pins
  input wire logic [ADDR_W-1:0] port_b_address_pins_i,
  output logic [ADDR_W-1:0] port_b_address_pins_o,
  output logic [ADDR_W-1:0] port_b_address_pins_oe,
  // narrow port address source
  input wire logic [ADDR_W-1:0] narrow_memory_port_addr,
  input wire logic narrow_memory_port_addr_oe,
  // configuration outputs
  output logic big_endian,
  output logic [1:0] boot_source,
  output logic [1:0] wide_port_clock_select,
  output logic [1:0] narrow_port_clock_select,
  output logic eeprom_auto_init_strap,
  output logic cell_bus_enable_strap,
  output logic serial_port_one_enable,
  output logic [2:0] variant_id,
  output logic config_valid
);
  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [ADDR_W-1:0] pin_sync;
  logic pin_stable;

  rscl_sync3 u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_in(port_b_address_pins_i),
    .pin_sync(pin_sync),
    .pin_stable(pin_stable)
  );

  // ----------------------------------------
  // local types and helpers
  // ----------------------------------------
  typedef enum logic [1:0] {
    RSCL_CAP_SETTLE = 2'b00,
    RSCL_CAP_WAIT = 2'b01,
    RSCL_CAP_HOLD = 2'b10
  } rscl_cap_state_t;

  // two-bit strap field at a pin position
  function automatic logic [1:0] strap_pair(input logic [ADDR_W-1:0] word, input int pos);
    return word[pos+:2];
  endfunction

  // single strap bit at a pin position
  function automatic logic strap_bit(input logic [ADDR_W-1:0] word, input int pos);
    return word[pos];
  endfunction

  // all pins driven or all released together
  function automatic logic [ADDR_W-1:0] drive_mask(input logic drive);
    return drive ? {ADDR_W{1'b1}} : {ADDR_W{1'b0}};
  endfunction

  // ----------------------------------------
  // capture sequencing after reset release
  // ----------------------------------------
  rscl_cap_state_t cap_state_reg, cap_state_next;
  logic [1:0] settle_reg, settle_next;
  logic take_strap;

  always_comb begin
    cap_state_next = cap_state_reg;
    settle_next = settle_reg;
    take_strap = 1'b0;
    unique case (cap_state_reg)
      RSCL_CAP_SETTLE: begin
        // pins stay inputs while the synchroniser flushes
        settle_next = settle_reg + 2'h1;
        if (settle_reg == SETTLE_CYCLES - 2'h1) begin
          cap_state_next = RSCL_CAP_WAIT;
        end
      end
      RSCL_CAP_WAIT: begin
        // a level counts only once stages two and three agree
        if (pin_stable) begin
          take_strap = 1'b1;
          cap_state_next = RSCL_CAP_HOLD;
        end
      end
      RSCL_CAP_HOLD: begin
        // later pin activity is address traffic, never a strap
        cap_state_next = RSCL_CAP_HOLD;
      end
      default: begin
        cap_state_next = RSCL_CAP_SETTLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_state_reg <= RSCL_CAP_SETTLE;
      settle_reg <= 2'h0;
    end else begin
      cap_state_reg <= cap_state_next;
      settle_reg <= settle_next;
    end
  end

  // ----------------------------------------
  // captured strap word
  // ----------------------------------------
  logic [ADDR_W-1:0] strap_reg, strap_next;
  logic valid_reg, valid_next;

  always_comb begin
    strap_next = strap_reg;
    valid_next = valid_reg;
    if (take_strap) begin
      strap_next = pin_sync;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_reg <= STRAP_RESET;
      valid_reg <= 1'b0;
    end else begin
      strap_reg <= strap_next;
      valid_reg <= valid_next;
    end
  end

  // ----------------------------------------
  // decoded configuration, one flop per output
  // ----------------------------------------
  logic endian_reg, endian_next;
  logic [1:0] boot_reg, boot_next;
  logic [1:0] wclk_reg, wclk_next;
  logic [1:0] nclk_reg, nclk_next;
  logic eeprom_auto_init_strap_reg, eeprom_auto_init_strap_next;
  logic cell_reg, cell_next;
  logic serial_reg, serial_next;
  logic [2:0] variant_reg, variant_next;

  always_comb begin
    // decoded from the next strap word so fields move with config_valid
    endian_next = strap_bit(strap_next, POS_ENDIAN);
    boot_next = strap_pair(strap_next, POS_BOOT);
    wclk_next = strap_pair(strap_next, POS_WCLK);
    nclk_next = strap_pair(strap_next, POS_NCLK);
    eeprom_auto_init_strap_next = strap_bit(strap_next, POS_EEPROM_AUTO_INIT_STRAP);
    cell_next = strap_bit(strap_next, POS_CELL);
    serial_next = ~strap_bit(strap_next, POS_CELL);
    // pins 7..9 identify the variant, passed on raw
    variant_next = strap_next[POS_ID_LO+:3];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      endian_reg <= STRAP_RESET[POS_ENDIAN];
      boot_reg <= STRAP_RESET[POS_BOOT+:2];
      wclk_reg <= STRAP_RESET[POS_WCLK+:2];
      nclk_reg <= STRAP_RESET[POS_NCLK+:2];
      eeprom_auto_init_strap_reg <= STRAP_RESET[POS_EEPROM_AUTO_INIT_STRAP];
      cell_reg <= STRAP_RESET[POS_CELL];
      serial_reg <= ~STRAP_RESET[POS_CELL];
      variant_reg <= STRAP_RESET[POS_ID_LO+:3];
    end else begin
      endian_reg <= endian_next;
      boot_reg <= boot_next;
      wclk_reg <= wclk_next;
      nclk_reg <= nclk_next;
      eeprom_auto_init_strap_reg <= eeprom_auto_init_strap_next;
      cell_reg <= cell_next;
      serial_reg <= serial_next;
      variant_reg <= variant_next;
    end
  end

  // ----------------------------------------
  // address drivers
  // ----------------------------------------
  logic [ADDR_W-1:0] ao_reg, ao_next;
  logic [ADDR_W-1:0] oe_reg, oe_next;

  always_comb begin
    ao_next = narrow_memory_port_addr;
    // driving before capture would fight the board straps
    oe_next = drive_mask(valid_reg && narrow_memory_port_addr_oe);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ao_reg <= '0;
      oe_reg <= '0;
    end else begin
      ao_reg <= ao_next;
      oe_reg <= oe_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // address pins
  assign port_b_address_pins_o = ao_reg;
  assign port_b_address_pins_oe = oe_reg;
  // configuration
  assign config_valid = valid_reg;
  assign big_endian = endian_reg;
  assign boot_source = boot_reg;
  assign wide_port_clock_select = wclk_reg;
  assign narrow_port_clock_select = nclk_reg;
  assign eeprom_auto_init_strap = eeprom_auto_init_strap_reg;
  assign cell_bus_enable_strap = cell_reg;
  assign serial_port_one_enable = serial_reg;
  assign variant_id = variant_reg;
endmodule
`default_nettype wire

// ==== rtl/rscl_sync3.sv ====
`timescale 1ns/1ns
`default_nettype none
module rscl_sync3
  import rscl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] pin_in,
  output logic [ADDR_W-1:0] pin_sync,
  output logic pin_stable
);
  logic [ADDR_W-1:0] s1_reg, s2_reg, s3_reg;
  logic [ADDR_W-1:0] s1_next, s2_next, s3_next;
  always_comb begin
    s1_next = pin_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= STRAP_RESET;
      s2_reg <= STRAP_RESET;
      s3_reg <= STRAP_RESET;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end
  assign pin_sync = s3_reg;
  assign pin_stable = (s2_reg == s3_reg);
endmodule
`default_nettype wire

// ==== test/rscl_strap_board.sv ====
`timescale 1ns/1ns
`default_nettype none
module rscl_strap_board
  import rscl_pkg::*;
(
  input wire logic [ADDR_W-1:0] strap,
  input wire logic [ADDR_W-1:0] port_b_address_pins_o,
  input wire logic [ADDR_W-1:0] port_b_address_pins_oe,
  output logic [ADDR_W-1:0] port_b_address_pins_i
);
  // a released pin settles to its pull resistor level
  always_comb begin
    for (int i = 0; i < ADDR_W; i++) begin
      port_b_address_pins_i[i] = port_b_address_pins_oe[i] ? port_b_address_pins_o[i] : strap[i];
    end
  end
endmodule
`default_nettype wire

// ==== test/rscl_strap_latch_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module rscl_strap_latch_props
  import rscl_pkg::*;
(
  input wire logic core_clk, arst_n, narrow_memory_port_addr_oe, config_valid,
  input wire logic [ADDR_W-1:0] port_b_address_pins_i, port_b_address_pins_o,
  input wire logic [ADDR_W-1:0] port_b_address_pins_oe, narrow_memory_port_addr,
  input wire logic big_endian, eeprom_auto_init_strap, cell_bus_enable_strap,
  input wire logic serial_port_one_enable,
  input wire logic [2:0] variant_id,
  input wire logic [1:0] boot_source, wide_port_clock_select, narrow_port_clock_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  oe_off_a: assert property (!config_valid |-> port_b_address_pins_oe == '0)
    else $error("drivers on before capture");
  hold_cfg_a: assert property ($past(config_valid) |-> $stable({big_endian, boot_source,
    wide_port_clock_select, narrow_port_clock_select, eeprom_auto_init_strap,
    cell_bus_enable_strap, serial_port_one_enable, variant_id}))
    else $error("config changed after capture");
  serial_inv_a: assert property (serial_port_one_enable == !cell_bus_enable_strap)
    else $error("serial enable not inverse of cell bus");
  addr_out_a: assert property (config_valid && narrow_memory_port_addr_oe |=>
    port_b_address_pins_oe == '1 && port_b_address_pins_o == $past(narrow_memory_port_addr))
    else $error("address not driven");
  float_a: assert property (!narrow_memory_port_addr_oe |=> port_b_address_pins_oe == '0)
    else $error("pins not floated");
  capture_a: assert property ($rose(config_valid) && $past(port_b_address_pins_i, 1) ==
    $past(port_b_address_pins_i, 4) |-> {big_endian, boot_source, wide_port_clock_select,
    narrow_port_clock_select} == $past(port_b_address_pins_i[19:13])) else $error("bad capture");
  valid_time_a: assert property ($rose(arst_n) |-> ##[1:8] config_valid)
    else $error("no capture after release");
  dflt_cfg_a: assert property (!config_valid |-> boot_source == 2'b10 &&
    !eeprom_auto_init_strap && !cell_bus_enable_strap) else $error("bad defaults");
endmodule
bind rscl_strap_latch rscl_strap_latch_props props_u (.*);
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import rscl_pkg::*;
;
  logic core_clk = 0, arst_n = 0, narrow_memory_port_addr_oe = 1, config_valid;
  logic [ADDR_W-1:0] port_b_address_pins_i, port_b_address_pins_o, port_b_address_pins_oe;
  logic [ADDR_W-1:0] narrow_memory_port_addr = 20'h5a5a5, strap = '0;
  logic big_endian, eeprom_auto_init_strap, cell_bus_enable_strap, serial_port_one_enable;
  logic [1:0] boot_source, wide_port_clock_select, narrow_port_clock_select;
  logic [2:0] variant_id;
  int bad_count = 0, check_count = 0;
  // straps 1 to 3 keep eeprom low as if pci were off; 2 and 3 have all id pins low
  logic [ADDR_W-1:0] tbl [4] = '{20'h8d040, 20'h36580, 20'h42000, 20'hf8400};
  wire logic [12:0] seen = {big_endian, boot_source, wide_port_clock_select,
    narrow_port_clock_select, eeprom_auto_init_strap, cell_bus_enable_strap,
    serial_port_one_enable, variant_id};
  rscl_strap_latch dut_u (.*);
  rscl_strap_board board_u (.*);
  always #2 core_clk = ~core_clk;
  function automatic logic [12:0] cfg(logic [ADDR_W-1:0] s);
    return {s[19:12], s[10], ~s[10], s[8:6]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic boot_up(logic [ADDR_W-1:0] s);
    int k;
    arst_n = 0;
    strap = s;
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1;
    for (k = 0; k < 20 && config_valid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (config_valid !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot_up(tbl[i]);
      chk("config", 20'(cfg(tbl[i])), 20'(seen));
      strap = ~tbl[i];
      repeat (4) @(posedge core_clk);
      #1 chk("held", 20'(cfg(tbl[i])), 20'(seen));
      $display("test strap %0d done", i);
    end
    chk("addr", 20'h5a5a5, port_b_address_pins_o);
    chk("drive", 20'hfffff, port_b_address_pins_oe);
    narrow_memory_port_addr_oe = 0;
    @(posedge core_clk);
    #1 chk("float", 20'h0, port_b_address_pins_oe);
    $display("test drive done");
    summarize();
  end
endmodule
`default_nettype wire
